// ==== bench/atahp_drive_model.sv ====
// Behavioural disk drive on the far side of the host port
`timescale 1ns/100ps
module atahp_drive_model (
   input  wire logic        clk_i,
   input  wire logic [2:0]  addr_i,
   input  wire logic        cs_ctl_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] dout_i,
   input  wire logic [7:0]  waits_i,
   input  wire logic        irq_i,
   output logic [15:0]      din_o,
   output logic             iordy_n_o,
   output logic             iocs16_n_o,
   output logic             intrq_o
);
   logic [15:0] mem [16];
   logic [15:0] last_q = 16'h0;
   logic [7:0]  cnt_q = 8'h0;
   logic        stb_q = 1'b0;
   wire  [3:0]  idx = {cs_ctl_i, addr_i};
   wire         first = (rd_i | wr_i) & ~stb_q;
   initial foreach (mem[i]) mem[i] = 16'h0;
   // Latch write data under the strobe; reload the wait count per strobe
   always @(posedge clk_i) begin
      stb_q <= rd_i | wr_i;
      if (wr_i) mem[idx] <= dout_i;
      if (rd_i) last_q <= mem[idx];
      if (first) cnt_q <= waits_i;
      else if (cnt_q != 8'h0) cnt_q <= cnt_q - 8'h1;
   end
   // Released lines show the inverse of the last value, not a stale copy
   assign din_o = rd_i ? mem[idx] : ~last_q;
   assign iordy_n_o = first ? (waits_i == 8'h0) : (cnt_q == 8'h0);
   assign iocs16_n_o = !(!cs_ctl_i && addr_i == 3'h0 && (rd_i | wr_i));
   assign intrq_o = irq_i;
endmodule

// ==== bench/atahp_port_bench.sv ====
// Self-checking bench for the ATA host port
`timescale 1ns/100ps
module atahp_port_bench;
   import atahp_pkg::*;
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin bad_count++; \
   $display("mismatch at %0t: got %h want %h", $time, a, b); end end
   logic        clk = 1'b0, rst = 1'b1, vld = 1'b0, drst = 1'b0, irq = 1'b0;
   logic [7:0]  waits = 8'h0;
   logic [31:0] bus = 32'h0;
   atahp_req_t  req = '0;
   atahp_rsp_t  rsp;
   logic [31:0] bus_o;
   logic [15:0] dout, din, shadow [16];
   logic [2:0]  addr;
   logic        rdy, rsp_v, cs_c, cs_t, rd, wr, rst_n, oe, iordy_n, iocs_n, intrq, d_irq;
   logic        wide_o;
   int          bad_count = 0, n_tests = 0, acc, got;
   atahp_port #(.STROBE_CYC(2), .RESET_CYC(8)) uut (.REF_CLK_I(clk), .RESET_I(rst),
      .REQ_VALID_I(vld), .REQ_READY_O(rdy), .REQ_I(req), .HOST_IO_DATA_BUS_I(bus),
      .RSP_VALID_O(rsp_v), .RSP_O(rsp), .HOST_IO_DATA_BUS_O(bus_o),
      .DRIVE_RESET_REQ_I(drst), .ATA_ADDR_O(addr), .ATA_CS_CTL_O(cs_c),
      .ATA_CS_TASK_O(cs_t), .ATA_READ_STB_O(rd), .ATA_WRITE_STB_O(wr),
      .ATA_RESET_N_O(rst_n), .ATA_DATA_I(din), .ATA_DATA_O(dout), .ATA_DATA_OE_O(oe),
      .ATA_IORDY_N_I(iordy_n), .ATA_IOCS16_N_I(iocs_n), .ATA_INTRQ_I(intrq),
      .DRIVE_IRQ_O(d_irq), .WIDE_SEEN_O(wide_o));
   atahp_drive_model drive (.clk_i(clk), .addr_i(addr), .cs_ctl_i(cs_c), .rd_i(rd),
      .wr_i(wr), .dout_i(dout), .waits_i(waits), .irq_i(irq), .din_o(din),
      .iordy_n_o(iordy_n), .iocs16_n_o(iocs_n), .intrq_o(intrq));
   always #2 clk = ~clk;
   // Register writes keep only the low byte of d, stored as the upper byte; low byte reads back all ones
   function automatic logic [15:0] stored(input logic wd, input logic [15:0] d);
      return wd ? d : {d[7:0], 8'hff};
   endfunction
   function automatic logic [31:0] exp_bus(input logic wd, input logic [15:0] s);
      return wd ? {s, 16'h0} : {8'h0, s[15:8], 16'h0};
   endfunction
   // One access; bus data is held until the completion, though the port takes it into the queue at the handshake
   task automatic op(input logic w, c, wd, input logic [2:0] a, input logic [15:0] d);
      int k;
      @(negedge clk);
      req = '{w, c, wd, a, d};
      bus = {d, 16'h0};
      vld = 1'b1;
      do @(posedge clk); while (rdy !== 1'b1);
      @(negedge clk);
      vld = 1'b0;
      k = 0;
      while (rsp_v !== 1'b1 && k < 400) begin @(posedge clk); #1; k++; end
      `CHK(rsp_v, 1'b1)
      if (w) shadow[{c, a}] = stored(wd, d);
      else begin
         `CHK(bus_o, exp_bus(wd, shadow[{c, a}]))
         `CHK(rsp.wide, !c && a == 3'h0)
         `CHK(wide_o, !c && a == 3'h0)
         `CHK(rsp.data, shadow[{c, a}])
      end
   endtask
   task automatic wrap_up;
      $display("comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   // Watchdog sized well past the longest expected run
   initial begin
      #300000;
      bad_count++;
      wrap_up;
   end
   initial begin
      void'($urandom(40766));
      repeat (3) @(negedge clk);
      `CHK(rst_n, 1'b0)
      rst = 1'b0;
      repeat (14) @(negedge clk);
      `CHK(rst_n, 1'b1)
      // Random write then readback, wait states growing to beyond the strobe
      for (int i = 0; i < 16; i++) begin
         waits = 8'(i * 3);
         req.ctl_grp = 1'($urandom);
         req.addr = 3'($urandom);
         op(1'b1, req.ctl_grp, 1'($urandom), req.addr, 16'($urandom));
         op(1'b0, req.ctl_grp, 1'($urandom), req.addr, 16'h0);
      end
      // Stall the drive and keep requesting until the queue refuses
      waits = 8'd60;
      acc = 0;
      @(negedge clk);
      req = '{1'b0, 1'b1, 1'b0, 3'h6, 16'h0};
      vld = 1'b1;
      // Ready seen at a falling edge decides the take at the next rising edge
      repeat (40) begin acc += int'(rdy === 1'b1); @(negedge clk); end
      `CHK(rdy, 1'b0)
      vld = 1'b0;
      waits = 8'h0;
      got = 0;
      repeat (900) begin @(posedge clk); #1; got += int'(rsp_v === 1'b1); end
      `CHK(got, acc)
      irq = 1'b1;
      repeat (4) @(negedge clk);
      `CHK(d_irq, 1'b1)
      irq = 1'b0;
      repeat (4) @(negedge clk);
      `CHK(d_irq, 1'b0)
      drst = 1'b1;
      @(negedge clk);
      drst = 1'b0;
      repeat (3) @(negedge clk);
      `CHK(rst_n, 1'b0)
      repeat (20) @(negedge clk);
      `CHK(rst_n, 1'b1)
      wrap_up;
   end
endmodule

// ==== bench/atahp_port_chk.sv ====
// Pin-level checks for the ATA host port
`timescale 1ns/100ps
module atahp_port_chk #(
   parameter int STROBE_CYC = 2
) (
   input  wire logic       REF_CLK_I,
   input  wire logic       RESET_I,
   input  wire logic       RSP_VALID_O,
   input  wire logic [2:0] ATA_ADDR_O,
   input  wire logic       ATA_CS_CTL_O,
   input  wire logic       ATA_CS_TASK_O,
   input  wire logic       ATA_READ_STB_O,
   input  wire logic       ATA_WRITE_STB_O,
   input  wire logic       ATA_RESET_N_O,
   input  wire logic       ATA_DATA_OE_O,
   input  wire logic       ATA_IORDY_N_I
);
   // Either strobe marks a drive cycle in flight
   wire stb = ATA_READ_STB_O | ATA_WRITE_STB_O;
   default clocking @(posedge REF_CLK_I); endclocking
   default disable iff (RESET_I);
   one_sel_a: assert property (stb |-> ATA_CS_CTL_O ^ ATA_CS_TASK_O)
      else $error("strobe without one select");
   stb_excl_a: assert property (!(ATA_READ_STB_O && ATA_WRITE_STB_O))
      else $error("both strobes high");
   wr_drive_a: assert property (ATA_WRITE_STB_O |-> ATA_DATA_OE_O)
      else $error("write strobe with bus released");
   rd_float_a: assert property (ATA_READ_STB_O |-> !ATA_DATA_OE_O)
      else $error("read strobe while driving");
   // Four low samples outlast the two-stage synchroniser
   wait_hold_a: assert property ((stb && !ATA_IORDY_N_I) [*4] |=> stb)
      else $error("strobe ended during wait");
   pins_hold_a: assert property (stb && $past(stb) |->
      $stable({ATA_ADDR_O, ATA_CS_CTL_O, ATA_CS_TASK_O}))
      else $error("pins moved during strobe");
   stb_min_a: assert property ($rose(stb) |-> stb [*2])
      else $error("strobe too short");
   done_pulse_a: assert property ($fell(stb) |-> ##[1:2] RSP_VALID_O)
      else $error("no completion after strobe");
   rst_out_a: assert property (disable iff (1'b0) RESET_I |=> !ATA_RESET_N_O)
      else $error("drive reset not asserted");
   quiet_rst_a: assert property (!ATA_RESET_N_O |-> !stb)
      else $error("strobe during drive reset");
   cover property ($fell(ATA_READ_STB_O));
   cover property ($fell(ATA_WRITE_STB_O));
   cover property (stb && !ATA_IORDY_N_I);
endmodule
bind atahp_port atahp_port_chk #(.STROBE_CYC(STROBE_CYC)) chk (.*);

// ==== src/atahp_defs.svh ====
// Timing counts and fixed values for the ATA host port
`ifndef ATAHP_DEFS_SVH
`define ATAHP_DEFS_SVH
`define ATAHP_CLK_PERIOD_NS   4
`define ATAHP_STROBE_MIN_NS   80
`define ATAHP_STROBE_CYC      ((`ATAHP_STROBE_MIN_NS + `ATAHP_CLK_PERIOD_NS - 1) / `ATAHP_CLK_PERIOD_NS)
`define ATAHP_RESET_MIN_NS    25000
`define ATAHP_RESET_CYC       ((`ATAHP_RESET_MIN_NS + `ATAHP_CLK_PERIOD_NS - 1) / `ATAHP_CLK_PERIOD_NS)
`define ATAHP_FIFO_DEPTH      8
`define ATAHP_REG_FILL        8'hff
`endif

// ==== src/atahp_pkg.sv ====
// Types shared by the ATA host port
package atahp_pkg;
   typedef struct packed {
      logic        write;     // 1 = write, 0 = read
      logic        ctl_grp;   // 1 = control/status group, 0 = task file
      logic        wide;      // 1 = 16-bit data port transfer
      logic [2:0]  addr;
      logic [15:0] data;
   } atahp_req_t;

   typedef struct packed {
      logic        wide;
      logic [15:0] data;
   } atahp_rsp_t;

   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_STROBE, ST_WAIT, ST_DONE} atahp_state_t;
endpackage

// ==== src/atahp_port.sv ====
// ATA host port: request FIFO, strobe sequencer, drive reset and pin sampling
//
// Contract
// - The three address lines pick the drive register, qualified by the asserted select.
// - Data port transfers use all sixteen data lines, taken from host bus bits 16 to 31.
// - Register accesses carry the byte on data lines 8 to 15, lines 0 to 7 forced high on writes.
// - The control/status select is asserted high for the control and status register group.
// - The task file select is asserted high for the command, address and count registers.
// - While the drive holds ready low the host stretches the cycle with wait states.
// - The 16-bit indication is low for data port accesses and marks a 16-bit transfer.
// - The host drives an active-low hardware reset to the drive.
// - The host pulses the read strobe and samples the data lines during it.
// - The host pulses the write strobe with the data lines driven while it is active.
`timescale 1ns/100ps
`include "atahp_defs.svh"

module atahp_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk_i,
   input  wire logic             rst_i,
   input  wire logic             in_valid_i,
   output logic                  in_ready_o,
   input  wire logic [WIDTH-1:0] in_data_i,
   output logic                  out_valid_o,
   input  wire logic             out_ready_i,
   output logic [WIDTH-1:0]      out_data_o
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   cnt;
   } atahp_fifo_st_t;

   atahp_fifo_st_t   s_q, s_d;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic             push, pop;

   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("atahp_fifo: DEPTH must be a power of two");
   end

   // Full and empty come straight from the count so back-pressure is exact
   assign in_ready_o  = (s_q.cnt != (AW+1)'(DEPTH));
   assign out_valid_o = (s_q.cnt != '0);
   assign out_data_o  = mem_q[s_q.rd];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   // Pointer and count update
   always_comb begin
      s_d = s_q;
      if (push) s_d.wr = s_q.wr + 1'b1;
      if (pop) s_d.rd = s_q.rd + 1'b1;
      if (push && !pop) s_d.cnt = s_q.cnt + 1'b1;
      else if (pop && !push) s_d.cnt = s_q.cnt - 1'b1;
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) s_q <= '0;
      else s_q <= s_d;
   end

   // Storage has no reset; only written words are ever read
   always_ff @(posedge clk_i) begin
      if (push) mem_q[s_q.wr] <= in_data_i;
   end
endmodule

module atahp_port
   import atahp_pkg::*;
#(
   parameter int FIFO_DEPTH  = `ATAHP_FIFO_DEPTH,
   parameter int STROBE_CYC  = `ATAHP_STROBE_CYC,
   parameter int RESET_CYC   = `ATAHP_RESET_CYC
) (
   // Clock and reset
   input  wire logic                REF_CLK_I,
   input  wire logic                RESET_I,
   // Host request stream
   input  wire logic                REQ_VALID_I,
   output logic                     REQ_READY_O,
   input  wire atahp_pkg::atahp_req_t REQ_I,
   input  wire logic [31:0]         HOST_IO_DATA_BUS_I,
   // Completion stream (one per request)
   output logic                     RSP_VALID_O,
   output atahp_pkg::atahp_rsp_t    RSP_O,
   output logic [31:0]              HOST_IO_DATA_BUS_O,
   // Software-driven drive reset request
   input  wire logic                DRIVE_RESET_REQ_I,
   // Drive pins
   output logic [2:0]               ATA_ADDR_O,
   output logic                     ATA_CS_CTL_O,
   output logic                     ATA_CS_TASK_O,
   output logic                     ATA_READ_STB_O,
   output logic                     ATA_WRITE_STB_O,
   output logic                     ATA_RESET_N_O,
   input  wire logic [15:0]         ATA_DATA_I,
   output logic [15:0]              ATA_DATA_O,
   output logic                     ATA_DATA_OE_O,
   input  wire logic                ATA_IORDY_N_I,
   input  wire logic                ATA_IOCS16_N_I,
   input  wire logic                ATA_INTRQ_I,
   // Drive status toward the host
   output logic                     DRIVE_IRQ_O,
   output logic                     WIDE_SEEN_O
);
   import atahp_pkg::*;

   localparam int CW = $clog2(RESET_CYC + 1);

   typedef struct packed {
      atahp_state_t st;
      atahp_req_t   cur;
      logic [CW-1:0] cnt;
      logic [CW-1:0] rst_cnt;
      logic [1:0]  rdy_s;
      logic [1:0]  cs16_s;
      logic [1:0]  irq_s;
      logic [15:0] rd_data;
      logic        rsp_v;
      logic        wide_seen;
      logic [2:0]  addr;
      logic        cs_ctl;
      logic        cs_task;
      logic        rd_stb;
      logic        wr_stb;
      logic [15:0] dout;
      logic        oe;
   } atahp_st_t;

   atahp_st_t  s_q, s_d;
   atahp_req_t fifo_req, in_req;
   logic       fifo_valid, fifo_pop;
   logic       drive_ready;

   initial begin
      if (STROBE_CYC < 1 || RESET_CYC < 1 || FIFO_DEPTH < 2 || STROBE_CYC > RESET_CYC)
         $error("atahp_port: bad timing or depth parameter");
   end

   // Data port words come from the upper half of the host bus
   always_comb begin
      in_req = REQ_I;
      if (REQ_I.wide) in_req.data = HOST_IO_DATA_BUS_I[31:16];
      else in_req.data = {HOST_IO_DATA_BUS_I[23:16], 8'h00};
   end

   // Requests queue here so a stalled drive backs up into the host
   atahp_fifo #(
      .WIDTH ($bits(atahp_req_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .clk_i       (REF_CLK_I),
      .rst_i       (RESET_I),
      .in_valid_i  (REQ_VALID_I),
      .in_ready_o  (REQ_READY_O),
      .in_data_i   (in_req),
      .out_valid_o (fifo_valid),
      .out_ready_i (fifo_pop),
      .out_data_o  (fifo_req)
   );

   assign drive_ready = s_q.rdy_s[1];   // ready line is active-low wait, high = ready
   assign fifo_pop    = (s_q.st == ST_IDLE) && fifo_valid && (s_q.rst_cnt == '0);

   // Sequencer: setup, minimum strobe, stretch on wait, release, complete
   always_comb begin
      s_d = s_q;
      s_d.rsp_v  = 1'b0;
      s_d.rdy_s  = {s_q.rdy_s[0], ATA_IORDY_N_I};
      s_d.cs16_s = {s_q.cs16_s[0], ATA_IOCS16_N_I};
      s_d.irq_s  = {s_q.irq_s[0], ATA_INTRQ_I};
      if (s_q.rst_cnt != '0) s_d.rst_cnt = s_q.rst_cnt - 1'b1;
      if (DRIVE_RESET_REQ_I) s_d.rst_cnt = CW'(RESET_CYC);
      unique case (s_q.st)
         ST_IDLE: begin
            if (fifo_pop) begin
               s_d.cur     = fifo_req;
               s_d.addr    = fifo_req.addr;
               s_d.cs_ctl  = fifo_req.ctl_grp;
               s_d.cs_task = !fifo_req.ctl_grp;
               s_d.oe      = fifo_req.write;
               // Register writes keep the low byte high
               s_d.dout    = fifo_req.wide ? fifo_req.data
                                           : {fifo_req.data[15:8], `ATAHP_REG_FILL};
               s_d.st      = ST_SETUP;
            end
         end
         ST_SETUP: begin
            // One cycle of address setup before the strobe
            s_d.rd_stb = !s_q.cur.write;
            s_d.wr_stb = s_q.cur.write;
            s_d.cnt    = CW'(STROBE_CYC);
            s_d.st     = ST_STROBE;
         end
         ST_STROBE: begin
            if (s_q.cnt > CW'(1)) s_d.cnt = s_q.cnt - 1'b1;
            else s_d.st = ST_WAIT;
         end
         ST_WAIT: begin
            // Hold everything while the drive asks for wait states
            if (drive_ready) begin
               s_d.rd_data   = ATA_DATA_I;
               s_d.wide_seen = !s_q.cs16_s[1];
               s_d.rd_stb    = 1'b0;
               s_d.wr_stb    = 1'b0;
               s_d.st        = ST_DONE;
            end
         end
         ST_DONE: begin
            // Selects drop one cycle after the strobe for hold time
            s_d.cs_ctl  = 1'b0;
            s_d.cs_task = 1'b0;
            s_d.oe      = 1'b0;
            s_d.rsp_v   = 1'b1;
            s_d.st      = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (RESET_I) begin
         s_q         <= '0;
         s_q.st      <= ST_IDLE;
         s_q.rst_cnt <= CW'(RESET_CYC);
         s_q.rdy_s   <= 2'b11;
         s_q.cs16_s  <= 2'b11;
      end else begin
         s_q <= s_d;
      end
   end

   // Pin and completion outputs from flip-flops; drive reset decoded from the reset count
   assign ATA_ADDR_O      = s_q.addr;
   assign ATA_CS_CTL_O    = s_q.cs_ctl;
   assign ATA_CS_TASK_O   = s_q.cs_task;
   assign ATA_READ_STB_O  = s_q.rd_stb;
   assign ATA_WRITE_STB_O = s_q.wr_stb;
   assign ATA_DATA_O      = s_q.dout;
   assign ATA_DATA_OE_O   = s_q.oe;
   assign ATA_RESET_N_O   = (s_q.rst_cnt == '0);
   assign RSP_VALID_O     = s_q.rsp_v;
   assign RSP_O           = '{wide: s_q.wide_seen, data: s_q.rd_data};
   // Register bytes return in bits 23:16, wide words in 31:16
   assign HOST_IO_DATA_BUS_O = s_q.cur.wide ? {s_q.rd_data, 16'h0000}
                                            : {8'h00, s_q.rd_data[15:8], 16'h0000};
   assign DRIVE_IRQ_O     = s_q.irq_s[1];
   assign WIDE_SEEN_O     = s_q.wide_seen;
endmodule
